// ### hdl/prox_pkg.sv
/*
 * Shared constants for the proximity sensor control block: register
 * byte addresses, field positions, sample timing and controller states.
 * Assumes a single 200 MHz system clock.
 */
package prox_pkg;

    // ------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_GAIN_COARSE   = 8'h00;
    localparam logic [7:0] ADDR_GAIN_FINE     = 8'h01;
    localparam logic [7:0] ADDR_OFFSET_COARSE = 8'h02;
    localparam logic [7:0] ADDR_OFFSET_FINE   = 8'h03;
    localparam logic [7:0] ADDR_TEMP_COEFF    = 8'h04;
    localparam logic [7:0] ADDR_PROBE_SEL     = 8'h05;
    localparam logic [7:0] ADDR_RESULT_LOW    = 8'h06;
    localparam logic [7:0] ADDR_RESULT_HIGH   = 8'h07;
    localparam logic [7:0] ADDR_TEMP_SENSOR   = 8'h08;
    localparam logic [7:0] ADDR_THRESHOLD     = 8'h09;
    localparam logic [7:0] ADDR_RATE_SEL      = 8'h0a;
    localparam logic [7:0] ADDR_ACCUM_SEL     = 8'h0b;
    localparam logic [7:0] ADDR_CURRENT_TRIM  = 8'h0c;
    localparam logic [7:0] ADDR_SLEEP_INTV    = 8'h0d;
    localparam logic [7:0] ADDR_DEV_ADDR      = 8'h0f;
    localparam logic [7:0] ADDR_NVM_INDEX     = 8'h40;
    localparam logic [7:0] ADDR_NVM_DATA_LO   = 8'h42;
    localparam logic [7:0] ADDR_NVM_DATA_HI   = 8'h43;
    localparam logic [7:0] ADDR_NVM_CTRL1     = 8'h44;
    localparam logic [7:0] ADDR_NVM_CTRL2     = 8'h45;
    localparam logic [7:0] ADDR_NVM_CTRL3     = 8'h46;

    // ------------------------------------------------------------
    // Field positions and sizes
    // ------------------------------------------------------------
    localparam int          GAIN_CAP_LSB = 0;
    localparam int          GAIN_DIF_LSB = 2;
    localparam int          GAIN_XFR_LSB = 4;
    localparam int          GAIN_POL_BIT = 7;
    localparam int          RES_W        = 10;
    localparam int          NVM_WORDS    = 8;
    localparam logic [2:0]  NVM_LAST     = 3'h7;
    localparam logic [2:0]  NVM_RES_WORD = 3'h3;
    localparam logic [13:0] ACCUM_BASE   = 14'h0400;

    // ------------------------------------------------------------
    // Sample timing
    // ------------------------------------------------------------
    localparam int CLK_FREQ_HZ         = 200_000_000;
    localparam int SAMPLE_FREQ_FAST_HZ = 40_000;
    localparam int SAMPLE_FREQ_SLOW_HZ = 20_000;
    localparam int SAMPLE_CYC_FAST     = CLK_FREQ_HZ / SAMPLE_FREQ_FAST_HZ;
    localparam int SAMPLE_CYC_SLOW     = CLK_FREQ_HZ / SAMPLE_FREQ_SLOW_HZ;

    // ------------------------------------------------------------
    // Controller states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_LOAD  = 4'h1,
        ST_CONV  = 4'h2,
        ST_IDLE  = 4'h4,
        ST_SLEEP = 4'h8
    } ctrl_state_t;

endpackage

// ### hdl/proximity_sensor_ctrl_regs.sv
/*
 * Register bank, conversion scheduler and threshold comparator of a
 * capacitive proximity sensor front end.
 * Assumes a byte-wide register port from the serial bus front end, a
 * nonvolatile word store read combinationally, and an analog
 * accumulator on the same clock that presents its sum when told.
 */
// Summary of operation
// - Registers are bytes; two consecutive registers share one 16-bit stored word.
// - Odd register of each pair maps to the upper byte of its word.
// - Device address changes only through the address setting procedure and the power-up copy of word 7.
// - Gain coarse bits 1:0 select the conversion capacitance.
// - Gain coarse bits 3:2 select the differential amplifier gain.
// - Gain coarse bits 5:4 select the charge transfer capacitor.
// - Gain coarse bit 7 sets the offset correction polarity.
// - Fine gain value sets conversion gain to one plus value over 255.
// - Coarse offset value sets correction of 8 pF times value over 255.
// - Fine offset value sets correction of 40 fF times value over 255.
// - Temperature trim sets coefficient from minus 1000 to plus 1000 ppm.
// - Probe select routes one of four nodes to the monitor pin.
// - Ten-bit result splits into high byte and bits 7:6 of low register.
// - Temperature sensor trim shifts sensor output by value-dependent volts.
// - Comparator pin high while high result byte exceeds the threshold.
// - Rate bit low gives 40 kHz sampling, high gives 20 kHz.
// - Accumulation field selects 1024, 2048, 4096 or 8192 samples.
// - Current trim lowers bias; software avoids values near 255.
// - Nonzero sleep interval N idles N conversion times between conversions.
// - Zero sleep interval converts continuously.
// - After each idle interval exactly one conversion runs, then idle again.
// - Conversion time follows from sample rate and accumulation count.
// - Sleep pin low stops all but registers; resumes when it rises.
// - After power-up stored words are copied into the function registers.
`timescale 1ns/100ps

module proximity_sensor_ctrl_regs #(
    parameter int SAMPLE_CYC_FAST = prox_pkg::SAMPLE_CYC_FAST,
    parameter int SAMPLE_CYC_SLOW = prox_pkg::SAMPLE_CYC_SLOW
) (
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    input  wire logic        addr_set,
    input  wire logic [6:0]  addr_set_value,
    output logic      [6:0]  bus_device_address,
    output logic      [2:0]  nvm_rd_index,
    input  wire logic [15:0] nvm_rd_data,
    output logic             load_busy,
    input  wire logic        sleep_pin,
    output logic             afe_active,
    output logic             sample_tick,
    output logic             conv_start,
    output logic             conv_done,
    input  wire logic [9:0]  afe_result,
    output logic      [1:0]  cvc_cap_sel,
    output logic      [1:0]  diff_gain_sel,
    output logic      [1:0]  transfer_cap_sel,
    output logic             offset_polarity,
    output logic      [7:0]  gain_fine_cfg,
    output logic      [7:0]  offset_coarse_cfg,
    output logic      [7:0]  offset_fine_cfg,
    output logic      [7:0]  temp_coeff_trim,
    output logic      [1:0]  probe_select,
    output logic      [7:0]  temp_sensor_trim,
    output logic      [7:0]  current_trim,
    output logic             above_threshold_out
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        prox_pkg::ctrl_state_t st;
        logic [7:0]  cgain;
        logic [7:0]  fgain;
        logic [7:0]  cofs;
        logic [7:0]  fofs;
        logic [7:0]  tco;
        logic [1:0]  probe;
        logic [9:0]  res;
        logic [7:0]  tsen;
        logic [7:0]  thr;
        logic        rate;
        logic [1:0]  accum;
        logic [7:0]  bias;
        logic [7:0]  intv;
        logic [6:0]  dev;
        logic [7:0]  n_idx;
        logic [7:0]  n_dlo;
        logic [7:0]  n_dhi;
        logic [7:0]  n_c1;
        logic [7:0]  n_c2;
        logic [7:0]  n_c3;
        logic [13:0] div;
        logic [13:0] smp;
        logic [7:0]  idle;
        logic [2:0]  ld_idx;
        logic [7:0]  rdata;
        logic        above;
        logic        tick;
        logic        start;
        logic        done;
        logic        sync_m;
        logic        sync_s;
    } state_t;

    localparam state_t RST_STATE = '{st: prox_pkg::ST_LOAD, default: '0};

    state_t      s_q;
    state_t      s_d;
    logic [13:0] period;
    logic [13:0] accum_last;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        s_d       = s_q;
        s_d.tick  = 1'b0;
        s_d.start = 1'b0;
        s_d.done  = 1'b0;
        s_d.sync_m = sleep_pin;
        s_d.sync_s = s_q.sync_m;
        period = s_q.rate ? 14'(SAMPLE_CYC_SLOW - 1) : 14'(SAMPLE_CYC_FAST - 1);
        accum_last = 14'((prox_pkg::ACCUM_BASE << s_q.accum) - 14'h0001);
        // Ordinary writes; result and address registers are not writable.
        if (reg_wr)
        begin
            case (reg_addr)
                prox_pkg::ADDR_GAIN_COARSE:   s_d.cgain = reg_wdata;
                prox_pkg::ADDR_GAIN_FINE:     s_d.fgain = reg_wdata;
                prox_pkg::ADDR_OFFSET_COARSE: s_d.cofs  = reg_wdata;
                prox_pkg::ADDR_OFFSET_FINE:   s_d.fofs  = reg_wdata;
                prox_pkg::ADDR_TEMP_COEFF:    s_d.tco   = reg_wdata;
                prox_pkg::ADDR_PROBE_SEL:     s_d.probe = reg_wdata[1:0];
                prox_pkg::ADDR_TEMP_SENSOR:   s_d.tsen  = reg_wdata;
                prox_pkg::ADDR_THRESHOLD:     s_d.thr   = reg_wdata;
                prox_pkg::ADDR_RATE_SEL:      s_d.rate  = reg_wdata[0];
                prox_pkg::ADDR_ACCUM_SEL:     s_d.accum = reg_wdata[1:0];
                prox_pkg::ADDR_CURRENT_TRIM:  s_d.bias  = reg_wdata;
                prox_pkg::ADDR_SLEEP_INTV:    s_d.intv  = reg_wdata;
                prox_pkg::ADDR_NVM_INDEX:     s_d.n_idx = reg_wdata;
                prox_pkg::ADDR_NVM_DATA_LO:   s_d.n_dlo = reg_wdata;
                prox_pkg::ADDR_NVM_DATA_HI:   s_d.n_dhi = reg_wdata;
                prox_pkg::ADDR_NVM_CTRL1:     s_d.n_c1  = reg_wdata;
                prox_pkg::ADDR_NVM_CTRL2:     s_d.n_c2  = reg_wdata;
                prox_pkg::ADDR_NVM_CTRL3:     s_d.n_c3  = reg_wdata;
                default:                      s_d.n_c3  = s_q.n_c3;
            endcase
        end
        if (addr_set)
        begin
            s_d.dev = addr_set_value;
        end
        // Read data is captured so the bus front end sees a stable byte.
        if (reg_rd)
        begin
            case (reg_addr)
                prox_pkg::ADDR_GAIN_COARSE:   s_d.rdata = s_q.cgain;
                prox_pkg::ADDR_GAIN_FINE:     s_d.rdata = s_q.fgain;
                prox_pkg::ADDR_OFFSET_COARSE: s_d.rdata = s_q.cofs;
                prox_pkg::ADDR_OFFSET_FINE:   s_d.rdata = s_q.fofs;
                prox_pkg::ADDR_TEMP_COEFF:    s_d.rdata = s_q.tco;
                prox_pkg::ADDR_PROBE_SEL:     s_d.rdata = {6'h00, s_q.probe};
                prox_pkg::ADDR_RESULT_LOW:    s_d.rdata = {s_q.res[1:0], 6'h00};
                prox_pkg::ADDR_RESULT_HIGH:   s_d.rdata = s_q.res[9:2];
                prox_pkg::ADDR_TEMP_SENSOR:   s_d.rdata = s_q.tsen;
                prox_pkg::ADDR_THRESHOLD:     s_d.rdata = s_q.thr;
                prox_pkg::ADDR_RATE_SEL:      s_d.rdata = {7'h00, s_q.rate};
                prox_pkg::ADDR_ACCUM_SEL:     s_d.rdata = {6'h00, s_q.accum};
                prox_pkg::ADDR_CURRENT_TRIM:  s_d.rdata = s_q.bias;
                prox_pkg::ADDR_SLEEP_INTV:    s_d.rdata = s_q.intv;
                prox_pkg::ADDR_DEV_ADDR:      s_d.rdata = {1'b0, s_q.dev};
                prox_pkg::ADDR_NVM_INDEX:     s_d.rdata = s_q.n_idx;
                prox_pkg::ADDR_NVM_DATA_LO:   s_d.rdata = s_q.n_dlo;
                prox_pkg::ADDR_NVM_DATA_HI:   s_d.rdata = s_q.n_dhi;
                prox_pkg::ADDR_NVM_CTRL1:     s_d.rdata = s_q.n_c1;
                prox_pkg::ADDR_NVM_CTRL2:     s_d.rdata = s_q.n_c2;
                prox_pkg::ADDR_NVM_CTRL3:     s_d.rdata = s_q.n_c3;
                default:                      s_d.rdata = 8'h00;
            endcase
        end
        case (s_q.st)
            prox_pkg::ST_LOAD:
            begin
                // One stored word per cycle; the load wins over bus writes.
                case (s_q.ld_idx)
                    3'h0:
                    begin
                        s_d.cgain = nvm_rd_data[7:0];
                        s_d.fgain = nvm_rd_data[15:8];
                    end
                    3'h1:
                    begin
                        s_d.cofs = nvm_rd_data[7:0];
                        s_d.fofs = nvm_rd_data[15:8];
                    end
                    3'h2:
                    begin
                        s_d.tco   = nvm_rd_data[7:0];
                        s_d.probe = nvm_rd_data[9:8];
                    end
                    3'h4:
                    begin
                        s_d.tsen = nvm_rd_data[7:0];
                        s_d.thr  = nvm_rd_data[15:8];
                    end
                    3'h5:
                    begin
                        s_d.rate  = nvm_rd_data[0];
                        s_d.accum = nvm_rd_data[9:8];
                    end
                    3'h6:
                    begin
                        s_d.bias = nvm_rd_data[7:0];
                        s_d.intv = nvm_rd_data[15:8];
                    end
                    3'h7:
                    begin
                        s_d.dev = nvm_rd_data[14:8];
                    end
                    default:
                    begin
                        // Result word is read-only and is not restored.
                        s_d.res = s_q.res;
                    end
                endcase
                s_d.ld_idx = s_q.ld_idx + 3'h1;
                if (s_q.ld_idx == prox_pkg::NVM_LAST)
                begin
                    s_d.st    = prox_pkg::ST_CONV;
                    s_d.start = 1'b1;
                    s_d.smp   = '0;
                    s_d.div   = period;
                end
            end
            prox_pkg::ST_CONV,
            prox_pkg::ST_IDLE:
            begin
                if (!s_q.sync_s)
                begin
                    s_d.st = prox_pkg::ST_SLEEP;
                end
                else if (s_q.div != 14'h0000)
                begin
                    s_d.div = s_q.div - 14'h0001;
                end
                else
                begin
                    s_d.div  = period;
                    s_d.tick = (s_q.st == prox_pkg::ST_CONV);
                    if (s_q.smp != accum_last)
                    begin
                        s_d.smp = s_q.smp + 14'h0001;
                    end
                    else
                    begin
                        s_d.smp = '0;
                        if (s_q.st == prox_pkg::ST_CONV)
                        begin
                            s_d.done = 1'b1;
                            s_d.res  = afe_result;
                            s_d.idle = 8'h00;
                            if (s_q.intv != 8'h00)
                            begin
                                s_d.st = prox_pkg::ST_IDLE;
                            end
                            else
                            begin
                                s_d.start = 1'b1;
                            end
                        end
                        else if (s_q.intv == 8'h00 || s_q.idle >= s_q.intv - 8'h01)
                        begin
                            s_d.st    = prox_pkg::ST_CONV;
                            s_d.start = 1'b1;
                        end
                        else
                        begin
                            s_d.idle = s_q.idle + 8'h01;
                        end
                    end
                end
            end
            prox_pkg::ST_SLEEP:
            begin
                // A conversion cut by sleep is discarded and restarted whole.
                s_d.smp  = '0;
                s_d.div  = period;
                s_d.idle = 8'h00;
                if (s_q.sync_s)
                begin
                    s_d.st    = prox_pkg::ST_CONV;
                    s_d.start = 1'b1;
                end
            end
            default:
            begin
                s_d.st     = prox_pkg::ST_LOAD;
                s_d.ld_idx = 3'h0;
            end
        endcase
        s_d.above = (s_d.res[9:2] > s_d.thr);
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_q <= RST_STATE;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign reg_rdata           = s_q.rdata;
    assign bus_device_address  = s_q.dev;
    assign nvm_rd_index        = s_q.ld_idx;
    assign load_busy           = (s_q.st == prox_pkg::ST_LOAD);
    assign afe_active          = (s_q.st == prox_pkg::ST_CONV);
    assign sample_tick         = s_q.tick;
    assign conv_start          = s_q.start;
    assign conv_done           = s_q.done;
    assign cvc_cap_sel         = s_q.cgain[prox_pkg::GAIN_CAP_LSB +: 2];
    assign diff_gain_sel       = s_q.cgain[prox_pkg::GAIN_DIF_LSB +: 2];
    assign transfer_cap_sel    = s_q.cgain[prox_pkg::GAIN_XFR_LSB +: 2];
    assign offset_polarity     = s_q.cgain[prox_pkg::GAIN_POL_BIT];
    assign gain_fine_cfg       = s_q.fgain;
    assign offset_coarse_cfg   = s_q.cofs;
    assign offset_fine_cfg     = s_q.fofs;
    assign temp_coeff_trim     = s_q.tco;
    assign probe_select        = s_q.probe;
    assign temp_sensor_trim    = s_q.tsen;
    // Values near full scale starve the bias; software must keep clear.
    assign current_trim        = s_q.bias;
    assign above_threshold_out = s_q.above;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    chk_cmp_output: assert property (
        conv_done |-> above_threshold_out == ($past(afe_result[9:2]) > s_q.thr))
        else $error("comparator output disagrees with result and threshold");
    chk_result_hold: assert property (
        $changed(s_q.res) |-> conv_done && !$past(load_busy))
        else $error("result changed outside a conversion end");
    chk_word_pairing: assert property (
        (load_busy && nvm_rd_index == 3'h1) |=>
        offset_fine_cfg == $past(nvm_rd_data[15:8]) &&
        offset_coarse_cfg == $past(nvm_rd_data[7:0]))
        else $error("stored word not split into low and high register");
    chk_addr_protect: assert property (
        (reg_wr && reg_addr == prox_pkg::ADDR_DEV_ADDR && !addr_set && !load_busy)
        |=> $stable(bus_device_address))
        else $error("device address changed by an ordinary write");
    chk_reserved_read: assert property (
        (reg_rd && reg_addr == 8'h0e) |=> reg_rdata == 8'h00)
        else $error("reserved address read nonzero");
    chk_low_result_read: assert property (
        (reg_rd && reg_addr == prox_pkg::ADDR_RESULT_LOW) |=>
        reg_rdata == {$past(s_q.res[1:0]), 6'h00})
        else $error("low result register layout wrong");
    chk_continuous_mode: assert property (
        (conv_done && $past(s_q.intv) == 8'h00 && $past(s_q.sync_s)) |->
        conv_start && afe_active)
        else $error("continuous mode did not restart conversion");
    chk_idle_entry: assert property (
        (conv_done && $past(s_q.intv) != 8'h00) |->
        s_q.st == prox_pkg::ST_IDLE ##1 !afe_active)
        else $error("intermittent mode did not idle after conversion");
    chk_idle_single: assert property (
        (s_q.st == prox_pkg::ST_IDLE ##1 afe_active) |-> conv_start)
        else $error("conversion after idle did not start cleanly");
    chk_sleep_stop: assert property (
        (s_q.st == prox_pkg::ST_SLEEP) |-> !sample_tick && !conv_done)
        else $error("activity while asleep");
    chk_gain_fields: assert property (
        (reg_wr && reg_addr == prox_pkg::ADDR_GAIN_COARSE && !load_busy) |=>
        {offset_polarity, transfer_cap_sel, diff_gain_sel, cvc_cap_sel} ==
        {$past(reg_wdata[7]), $past(reg_wdata[5:0])})
        else $error("gain coarse fields misrouted");
    cov_continuous: cover property (conv_done ##1 afe_active [*8]);
    cov_idle_wake:  cover property (s_q.st == prox_pkg::ST_IDLE ##1 conv_start);
    cov_sleep_wake: cover property (s_q.st == prox_pkg::ST_SLEEP ##1 conv_start);
    cov_cmp_rise:   cover property ($rose(above_threshold_out));

endmodule

// ### verif/nvm_store_model.sv
/* Stored word model facing the power-up copy port of the register block.
   Assumes the index is read combinationally within one cycle. */
`timescale 1ns/100ps
module nvm_store_model (
    input  wire logic [2:0]  nvm_rd_index,
    output logic      [15:0] nvm_rd_data
);
    // Word 3 is all ones so that a wrongly restored result shows up.
    always_comb
    begin
        case (nvm_rd_index)
            3'h0:    nvm_rd_data = 16'ha512;
            3'h1:    nvm_rd_data = 16'h3c7e;
            3'h2:    nvm_rd_data = 16'h0281;
            3'h3:    nvm_rd_data = 16'hffff;
            3'h4:    nvm_rd_data = 16'h40c3;
            3'h6:    nvm_rd_data = 16'h00d4;
            3'h7:    nvm_rd_data = 16'hd5ee;
            default: nvm_rd_data = 16'h0000;
        endcase
    end
endmodule

// ### verif/proximity_sensor_ctrl_regs_test.sv
/* Self-checking bench: power-up copy, register map, conversions, sleep.
   Assumes shortened sample periods of 4 and 8 cycles. */
`timescale 1ns/100ps
module proximity_sensor_ctrl_regs_test;
    logic        clock, rst_n, reg_wr, reg_rd, addr_set, sleep_pin, load_busy;
    logic        afe_active, sample_tick, conv_start, conv_done;
    logic        offset_polarity, above_threshold_out;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, current_trim, gain_fine_cfg, offset_coarse_cfg;
    logic [7:0]  offset_fine_cfg, temp_coeff_trim, temp_sensor_trim;
    logic [6:0]  addr_set_value, bus_device_address;
    logic [2:0]  nvm_rd_index;
    logic [15:0] nvm_rd_data;
    logic [9:0]  afe_result;
    logic [1:0]  cvc_cap_sel, diff_gain_sel, transfer_cap_sel, probe_select;
    int          n_fail, cmp_count, cyc, n, t;
    logic [7:0]  ld_exp [16] = '{8'h12, 8'ha5, 8'h7e, 8'h3c, 8'h81, 8'h02, 8'h00, 8'h00,
                                 8'hc3, 8'h40, 8'h00, 8'h00, 8'hd4, 8'h00, 8'h00, 8'h55};

    proximity_sensor_ctrl_regs #(.SAMPLE_CYC_FAST(4), .SAMPLE_CYC_SLOW(8)) dut_u (
        .clock, .rst_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .addr_set,
        .addr_set_value, .bus_device_address, .nvm_rd_index, .nvm_rd_data, .load_busy,
        .sleep_pin, .afe_active, .sample_tick, .conv_start, .conv_done, .afe_result,
        .cvc_cap_sel, .diff_gain_sel, .transfer_cap_sel, .offset_polarity, .gain_fine_cfg,
        .offset_coarse_cfg, .offset_fine_cfg, .temp_coeff_trim, .probe_select,
        .temp_sensor_trim, .current_trim, .above_threshold_out);
    nvm_store_model store_u (.nvm_rd_index, .nvm_rd_data);

    initial
    begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 80000)
        begin
            n_fail++;
            finish_test;
        end
    end

    task automatic finish_test;
        if (n_fail == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
        @(posedge clock);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(posedge clock);
        check(reg_rdata, e);
    endtask

    // Counts cycles and sample ticks up to the next start or done pulse.
    task automatic wait_ev(input bit done);
        n = 0;
        t = 0;
        do
        begin
            @(posedge clock);
            n++;
            t += sample_tick;
        end while (!(done ? conv_done : conv_start) && n < 20000);
    endtask

    function automatic logic [7:0] rmask(input logic [7:0] a);
        case (a)
            8'h05, 8'h0b:               return 8'h03;
            8'h0a:                      return 8'h01;
            8'h0f:                      return 8'h55;
            8'h06, 8'h07, 8'h0e, 8'h41: return 8'h00;
            default:
                return (a < 8'h10 || (a > 8'h3f && a < 8'h47)) ? 8'hff : 8'h00;
        endcase
    endfunction

    initial
    begin
        {rst_n, reg_wr, reg_rd, addr_set, reg_addr, reg_wdata, addr_set_value, afe_result} = '0;
        sleep_pin = 1'b1;
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        repeat (10) @(posedge clock);
        check(load_busy, 1'b0);
        for (int a = 0; a < 16; a++)
            rd_chk(8'(a), ld_exp[a]);
        check(bus_device_address, 7'h55);
        check({gain_fine_cfg, offset_coarse_cfg, offset_fine_cfg, temp_coeff_trim}, 32'ha57e3c81);
        check(temp_sensor_trim, 8'hc3);
        wr(8'h00, 8'hb9);
        check({offset_polarity, transfer_cap_sel, diff_gain_sel, cvc_cap_sel}, 7'h79);
        for (int a = 0; a < 8'h48; a++)
        begin
            // The bias trim is kept well clear of full scale, as software must.
            wr(8'(a), (a == 12) ? 8'h3c : 8'hff);
            rd_chk(8'(a), (a == 12) ? 8'h3c : rmask(8'(a)));
        end
        check({probe_select, current_trim}, 10'h33c);
        wr(8'h0a, 8'h00);
        wr(8'h0b, 8'h00);
        wr(8'h0d, 8'h00);
        wr(8'h09, 8'hb1);
        addr_set_value <= 7'h2a;
        addr_set <= 1'b1;
        @(posedge clock);
        addr_set <= 1'b0;
        @(posedge clock);
        rd_chk(8'h0f, 8'h2a);
        afe_result <= 10'h2c6;
        wait_ev(0);
        wait_ev(1);
        check(n, 4096);
        check(t, 1024);
        check(above_threshold_out, 1'b0);
        rd_chk(8'h07, 8'hb1);
        rd_chk(8'h06, 8'h80);
        wr(8'h09, 8'hb0);
        check(above_threshold_out, 1'b1);
        wr(8'h0d, 8'h01);
        wait_ev(1);
        wait_ev(0);
        check(n, 4096);
        check(t, 0);
        wr(8'h0d, 8'h00);
        wait_ev(1);
        check(conv_start, 1'b1);
        wr(8'h0a, 8'h01);
        wr(8'h0b, 8'h01);
        wait_ev(0);
        wait_ev(1);
        check(n, 16384);
        sleep_pin <= 1'b0;
        afe_result <= 10'h000;
        repeat (6) @(posedge clock);
        check({afe_active, sample_tick}, 2'b00);
        rd_chk(8'h07, 8'hb1);
        sleep_pin <= 1'b1;
        wait_ev(0);
        check(n < 8, 1'b1);
        finish_test;
    end
endmodule
